// [rtl/ep0_ctrl_pkg.sv]
// package: register map, fields, reset values and speed codes for the endpoint 0 control block
package ep0_ctrl_pkg;
   // word indices (byte offset divided by four), compared against paddr[11:2]
   localparam logic [8:0] IDX_CSR_HIGH   = 9'h103;
   localparam logic [8:0] IDX_RX_COUNT   = 9'h108;
   localparam logic [8:0] IDX_TGT_SPEED  = 9'h10a;
   localparam logic [8:0] IDX_FIFO_PORT  = 9'h120;
   localparam int         ADDR_W         = 12;
   // field positions and widths
   localparam int         FLUSH_BIT      = 0;
   localparam int         COUNT_W        = 7;
   localparam int         SPEED_LSB      = 6;
   // reset values
   localparam logic [1:0] SPEED_RESET    = 2'h0;
   localparam logic [6:0] COUNT_RESET    = 7'h00;
   // speed codes
   localparam logic [1:0] SPEED_FULL     = 2'h2;
   localparam logic [1:0] SPEED_LOW      = 2'h3;
   // fifo depth in bytes
   localparam int         FIFO_DEPTH     = 64;
   typedef enum logic [1:0] {
      SPD_RESERVED,
      SPD_FULL,
      SPD_LOW
   } speed_e;
endpackage

// [rtl/ep0_fifo_mem.sv]
// byte memory of the endpoint 0 fifo with registered read data
`timescale 1ns/1ps
module ep0_fifo_mem #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   // clock
   input  wire logic          clk,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // read side
   input  wire logic [AW-1:0] rd_addr,
   output logic [7:0]         rd_data
);
   logic [7:0] mem [DEPTH];

   // write port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// [rtl/usb_ep0_fifo_control.sv]
// endpoint 0 fifo control: flush, receive byte count and target speed behind apb
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module usb_ep0_fifo_control #(
   parameter int DEPTH = ep0_ctrl_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link side: received bytes into the fifo
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_packet_done,
   // link side: transmit packet loaded by software
   input  wire logic        tx_packet_set,
   input  wire logic        tx_packet_sent,
   // status out to the controller
   output logic             tx_packet_ready,
   output logic             rx_packet_ready,
   output logic             flush_active,
   output logic             speed_full,
   output logic             speed_low,
   output logic             speed_same
);
   // pointer width from the fifo depth
   localparam int AW = $clog2(DEPTH);

   logic [AW-1:0]  wr_ptr_reg;
   logic [AW-1:0]  rd_ptr_reg;
   logic [AW:0]    level_reg;
   logic [1:0]     speed_reg;
   logic           flush_pend_reg;
   logic           wr_hit_reg;
   logic [7:0]     wr_byte_reg;
   logic [7:0]     mem_rd_data;
   logic           setup_wr;
   logic           setup_rd;
   logic           access_wr;
   logic           flush_req;
   logic           fifo_push;
   logic           fifo_pop;
   logic [9:0]     addr_word;
   logic           hit_csr;
   logic           hit_count;
   logic           hit_speed;
   logic           hit_fifo;
   ep0_ctrl_pkg::speed_e speed_dec;

   // word index of the bus address and register hits
   assign addr_word = paddr[11:2];
   assign hit_csr   = (addr_word == {1'b0, ep0_ctrl_pkg::IDX_CSR_HIGH});
   assign hit_count = (addr_word == {1'b0, ep0_ctrl_pkg::IDX_RX_COUNT});
   assign hit_speed = (addr_word == {1'b0, ep0_ctrl_pkg::IDX_TGT_SPEED});
   assign hit_fifo  = (addr_word == {1'b0, ep0_ctrl_pkg::IDX_FIFO_PORT});
   // setup decode for the answer, completed access for write effects
   assign setup_wr  = psel && !penable && pwrite;
   assign setup_rd  = psel && !penable && !pwrite;
   assign access_wr = psel && penable && pready && pwrite;
   // flush request: completed write with bit 0 set to the control/status high register
   assign flush_req = access_wr && hit_csr && pwdata[ep0_ctrl_pkg::FLUSH_BIT];
   // pushes stop at the full mark, so the count saturates at the depth
   assign fifo_push = rx_byte_valid && (level_reg < (AW+1)'(DEPTH)) && !flush_pend_reg;
   // a pop only on a read of the data port of a non-empty fifo
   assign fifo_pop  = setup_rd && hit_fifo && (level_reg != '0);

   // speed field decode
   always_comb begin
      case (speed_reg)
         ep0_ctrl_pkg::SPEED_FULL: speed_dec = ep0_ctrl_pkg::SPD_FULL;
         ep0_ctrl_pkg::SPEED_LOW:  speed_dec = ep0_ctrl_pkg::SPD_LOW;
         default:                  speed_dec = ep0_ctrl_pkg::SPD_RESERVED;
      endcase
   end

   // fifo storage
   ep0_fifo_mem #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk     (clk),
      .wr_en   (fifo_push),
      .wr_addr (wr_ptr_reg),
      .wr_data (rx_byte),
      .rd_addr (rd_ptr_reg),
      .rd_data (mem_rd_data)
   );

   // flush pending: set by write of one, cleared by hardware next cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flush_pend_reg <= 1'b0;
      end else if (flush_req) begin
         flush_pend_reg <= 1'b1;
      end else begin
         flush_pend_reg <= 1'b0;
      end
   end

   // fifo pointers and fill level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else if (flush_pend_reg) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         if (fifo_push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (fifo_pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         level_reg <= level_reg + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
      end
   end

   // packet ready flags; flush clears them (flag set wins over flush)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_packet_ready <= 1'b0;
         rx_packet_ready <= 1'b0;
      end else begin
         if (tx_packet_set) begin
            tx_packet_ready <= 1'b1;
         end else if (flush_pend_reg || tx_packet_sent) begin
            tx_packet_ready <= 1'b0;
         end
         if (rx_packet_done) begin
            rx_packet_ready <= 1'b1;
         end else if (flush_pend_reg) begin
            rx_packet_ready <= 1'b0;
         end
      end
   end

   // target speed register; reserved bits not stored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_reg <= ep0_ctrl_pkg::SPEED_RESET;
      end else if (access_wr && hit_speed) begin
         speed_reg <= pwdata[ep0_ctrl_pkg::SPEED_LSB +: 2];
      end
   end

   // speed outputs and flush pulse to the link logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_full   <= 1'b0;
         speed_low    <= 1'b0;
         speed_same   <= 1'b1;
         flush_active <= 1'b0;
      end else begin
         speed_full   <= (speed_dec == ep0_ctrl_pkg::SPD_FULL);
         speed_low    <= (speed_dec == ep0_ctrl_pkg::SPD_LOW);
         speed_same   <= (speed_dec == ep0_ctrl_pkg::SPD_RESERVED);
         flush_active <= flush_req;
      end
   end

   // last pushed byte: the memory read on a write edge still shows the old word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_hit_reg  <= 1'b0;
         wr_byte_reg <= 8'h00;
      end else begin
         wr_hit_reg  <= fifo_push && (wr_ptr_reg == rd_ptr_reg);
         wr_byte_reg <= rx_byte;
      end
   end

   // apb answer in the access cycle; fifo data from the registered memory port, or the last pushed byte on a write hit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (setup_rd) begin
            if (hit_csr) begin
               prdata <= '0;
            end else if (hit_count) begin
               prdata <= {25'h0, ep0_ctrl_pkg::COUNT_W'(level_reg)};
            end else if (hit_speed) begin
               prdata <= {24'h0, speed_reg, 6'h00};
            end else if (hit_fifo) begin
               if (level_reg == '0) begin
                  prdata <= '0;
               end else if (wr_hit_reg) begin
                  prdata <= {24'h0, wr_byte_reg};
               end else begin
                  prdata <= {24'h0, mem_rd_data};
               end
            end else begin
               prdata  <= '0;
               pslverr <= 1'b1;
            end
         end else if (setup_wr) begin
            pslverr <= !(hit_csr || hit_count || hit_speed || hit_fifo);
         end
      end
   end
endmodule

// [verif/ep0_ctrl_assertions.sv]
// checker: apb and status relations of the endpoint 0 control block
`timescale 1ns/1ps
module ep0_ctrl_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        tx_packet_ready,
   input wire logic        rx_packet_ready,
   input wire logic        flush_active,
   input wire logic        speed_full,
   input wire logic        speed_low,
   input wire logic        speed_same
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // setup cycle of an apb transfer
   wire setup = psel && !penable;
   // completed access of an apb transfer, where writes take effect
   wire access = psel && penable && pready;
   flush_pulse_a: assert property (access && pwrite && paddr == 12'h40c && pwdata[0] |=> flush_active)
      else $error("flush write gave no flush pulse");
   flush_noop_a: assert property (access && pwrite && paddr == 12'h40c && !pwdata[0] |=> !flush_active)
      else $error("flush pulse on a zero write");
   flush_done_a: assert property (flush_active |=> !flush_active && !rx_packet_ready && !tx_packet_ready)
      else $error("flush did not end or left a flag set");
   flush_bit_a: assert property (setup && !pwrite && paddr == 12'h40c |=> pready && prdata == 32'h0)
      else $error("flush bit read back set");
   count_read_a: assert property (setup && !pwrite && paddr == 12'h420 |=> pready && prdata[31:7] == 25'h0)
      else $error("count read wider than seven bits");
   speed_read_a: assert property (setup && !pwrite && paddr == 12'h428 |=> prdata[5:0] == 6'h0)
      else $error("speed reserved bits read nonzero");
   speed_low_a: assert property (access && pwrite && paddr == 12'h428 && pwdata[7:6] == 2'h3
      |-> ##[1:2] speed_low && !speed_full)
      else $error("low speed code not decoded");
   speed_one_a: assert property ($onehot({speed_full, speed_low, speed_same}))
      else $error("speed decode not one hot");
   cover property (flush_active);
   cover property (speed_low);
   cover property (rx_packet_ready && psel);
endmodule
bind usb_ep0_fifo_control ep0_ctrl_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .tx_packet_ready, .rx_packet_ready, .flush_active, .speed_full, .speed_low, .speed_same);

// [verif/usb_peer_model.sv]
// usb peer: feeds received bytes and packet events
`timescale 1ns/1ps
module usb_peer_model (
   // link side
   input  wire logic clk,
   output logic       rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic       rx_packet_done,
   output logic       tx_packet_set,
   output logic       tx_packet_sent
);
   // first byte of the last packet, for the fifo read check
   logic [7:0] first_byte;
   initial {rx_byte_valid, rx_byte, rx_packet_done, tx_packet_set, tx_packet_sent} = '0;
   // one-cycle transmit event: loaded or sent, then one settling edge
   task automatic tx_event(input logic sent);
      @(posedge clk);
      tx_packet_set  <= !sent;
      tx_packet_sent <= sent;
      @(posedge clk);
      tx_packet_set  <= 1'b0;
      tx_packet_sent <= 1'b0;
      @(posedge clk);
   endtask
   // one packet of n bytes, gap idle cycles between bytes
   task automatic send(input int n, input int gap);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         if (i == 0) first_byte = b;
         @(posedge clk);
         rx_byte_valid <= 1'b1;
         rx_byte       <= b;
         repeat (gap) begin
            @(posedge clk);
            rx_byte_valid <= 1'b0;
            rx_byte       <= ~rx_byte; // idle data never stale
         end
      end
      @(posedge clk);
      rx_byte_valid  <= 1'b0;
      rx_packet_done <= 1'b1;
      @(posedge clk);
      rx_packet_done <= 1'b0;
   endtask
endmodule

// [verif/test_usb_ep0_fifo_control.sv]
// testbench: endpoint 0 flush, byte count and target speed over apb
`timescale 1ns/1ps
module test_usb_ep0_fifo_control;
   logic        clk, rst, psel, penable, pwrite, pslverr, pready, err, rx_byte_valid, rx_packet_done;
   logic        tx_packet_set, tx_packet_sent, tx_packet_ready, rx_packet_ready, flush_active;
   logic        speed_full, speed_low, speed_same;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [7:0]  rx_byte;
   int          fail_count, check_count, cyc, n;
   usb_ep0_fifo_control dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rx_byte_valid, .rx_byte, .rx_packet_done, .tx_packet_set, .tx_packet_sent, .tx_packet_ready,
      .rx_packet_ready, .flush_active, .speed_full, .speed_low, .speed_same);
   usb_peer_model peer (.clk, .rx_byte_valid, .rx_byte, .rx_packet_done, .tx_packet_set, .tx_packet_sent);
   // clock and hang limit
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // apb master transfer; waits on pready, only the bench limit ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] exp_cnt(int k);
      return (k > ep0_ctrl_pkg::FIFO_DEPTH) ? 32'(ep0_ctrl_pkg::FIFO_DEPTH) : 32'(k);
   endfunction
   function automatic logic [31:0] exp_spd(logic [1:0] c);
      return {29'h0, c == ep0_ctrl_pkg::SPEED_FULL, c == ep0_ctrl_pkg::SPEED_LOW, c < 2'h2};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      {clk, psel, penable, pwrite, paddr, pwdata, fail_count, check_count, cyc} = '0;
      rst = 1'b1;
      void'($urandom(32'h394e));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(0, 12'h420, 0);
      chk("count reset", 32'h0, rdata);
      apb(0, 12'h428, 0);
      chk("speed reset", 32'h0, rdata);
      apb(0, 12'h7fc, 0);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1, 12'h7f8, 32'(32'($urandom)));
      chk("unmapped write error", 32'h1, 32'(err));
      $display("reset test done");
      // program the speed before any traffic
      for (int c = 0; c < 4; c++) begin
         apb(1, 12'h428, {24'($urandom), 2'(c), 6'h3f});
         apb(0, 12'h428, 0);
         chk("speed reg", {24'h0, 2'(c), 6'h0}, rdata);
         chk("speed flags", exp_spd(2'(c)), {29'h0, speed_full, speed_low, speed_same});
      end
      // read-modify-write keeps the reserved bits as read
      apb(0, 12'h428, 0);
      apb(1, 12'h428, {rdata[31:8], ep0_ctrl_pkg::SPEED_FULL, rdata[5:0]});
      apb(0, 12'h428, 0);
      chk("speed rmw", {24'h0, ep0_ctrl_pkg::SPEED_FULL, 6'h00}, rdata);
      // transmit flag set and cleared by link events
      peer.tx_event(1'b0);
      chk("tx ready set", 32'h1, 32'(tx_packet_ready));
      peer.tx_event(1'b1);
      chk("tx ready clear", 32'h0, 32'(tx_packet_ready));
      $display("speed test done");
      for (int i = 0; i < 4; i++) begin
         n = (i == 0) ? 64 : $urandom_range(70, 1);
         peer.send(n, $urandom_range(2, 0));
         apb(1, 12'h420, 32'h0000_007f);
         apb(0, 12'h420, 0);
         chk("count", exp_cnt(n), rdata);
         chk("rx ready", 32'h1, 32'(rx_packet_ready));
         apb(1, 12'h40c, 32'hffff_fffe);
         apb(0, 12'h420, 0);
         chk("count kept", exp_cnt(n), rdata);
         apb(0, 12'h480, 0);
         chk("fifo byte", {24'h0, peer.first_byte}, rdata);
         apb(0, 12'h420, 0);
         chk("count after pop", exp_cnt(n) - 32'h1, rdata);
         apb(1, 12'h40c, 32'h1);
         apb(0, 12'h40c, 0);
         chk("flush bit", 32'h0, rdata);
         apb(0, 12'h420, 0);
         chk("count flushed", 32'h0, rdata);
         chk("rx cleared", 32'h0, 32'(rx_packet_ready));
         $display("flush test %0d with %0d bytes done", i, n);
      end
      tally_and_finish();
   end
endmodule
